// ### logic/risc_core_sequencer.sv
// instruction sequencer, return stack, alu and wishbone register slave
//
// Implementation choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ps

module risc_core_sequencer #(
  parameter int          STACK_DEPTH = risc_core_pkg::STACK_DEPTH_DEF,
  parameter logic [11:0] INT_VECTOR  = risc_core_pkg::INT_VECTOR_DEF
) (
  // clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  // wishbone slave
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [3:0]              wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  // program memory
  output logic      [11:0]             pm_addr_o,
  input  wire logic [15:0]             pm_data_i,
  // data memory
  output risc_core_pkg::dm_req_s       dm_req_o,
  input  wire logic [7:0]              dm_rdata_i,
  // interrupt and phase
  input  wire logic                    irq_i,
  output logic                         int_ack_o,
  output logic      [3:0]              instruction_phase_clocks_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam int              SP_W    = $clog2(STACK_DEPTH + 1);
  localparam logic [SP_W-1:0] SP_FULL = SP_W'(STACK_DEPTH);

  risc_core_pkg::phase_e   phase_r;
  risc_core_pkg::instr_s   pf_r;
  risc_core_pkg::instr_s   ir_r;
  risc_core_pkg::status_s  st_r;
  risc_core_pkg::alu_res_s res_r;
  risc_core_pkg::alu_res_s alu_now;
  logic [11:0]             pc_r;
  logic                    pf_valid_r;
  logic                    ir_valid_r;
  logic [7:0]              opnd_r;
  logic [7:0]              acc_r;
  logic [11:0]             stk_r [STACK_DEPTH];
  logic [SP_W-1:0]         sp_r;
  logic                    int_pend_r;
  logic                    int_en_r;
  logic                    pcl_wb_pend_r;
  logic [7:0]              pcl_wb_val_r;
  logic [15:0]             ir_raw;
  logic                    is_jmp;
  logic                    alu_op;
  logic                    is_ret;
  logic                    skip;
  logic                    wr_mem;
  logic                    wr_acc;
  logic                    pcl_wr;
  logic                    full;
  logic                    xfer;
  logic                    pcl_wb_go;
  logic                    ack;
  logic                    push;
  logic                    pop;
  logic                    t4;
  logic [11:0]             push_val;
  logic                    wb_wr;

  // ----------------------------------------------------------------
  // decode of the executing instruction
  // ----------------------------------------------------------------
  // all transfer decisions settle by the last phase
  always_comb begin
    ir_raw    = ir_r;
    t4        = (phase_r == risc_core_pkg::PH_T4);
    is_jmp    = ir_valid_r && (ir_r.cls == risc_core_pkg::CLS_JUMP);
    alu_op    = ir_valid_r && !is_jmp;
    is_ret    = alu_op && (ir_r.op inside {risc_core_pkg::OP_RET,
                                           risc_core_pkg::OP_RETURN_FROM_INTERRUPT});
    skip      = alu_op && (((ir_r.op inside {risc_core_pkg::OP_SZ, risc_core_pkg::OP_SIZ,
                                              risc_core_pkg::OP_SDZ}) && res_r.st.z)
                || (ir_r.op == risc_core_pkg::OP_SNZ && !res_r.st.z));
    wr_mem    = alu_op && ir_r.to_mem && risc_core_pkg::writes(ir_r.op)
                && (ir_r.op != risc_core_pkg::OP_DAA);
    wr_acc    = alu_op && risc_core_pkg::writes(ir_r.op) && !wr_mem;
    pcl_wr    = wr_mem && (ir_r.addr == risc_core_pkg::PCL_DM_ADDR);
    full      = (sp_r == SP_FULL);
    xfer      = is_jmp || is_ret || skip || pcl_wr;
    pcl_wb_go = pcl_wb_pend_r && !xfer;
    ack       = int_pend_r && int_en_r && !full && !xfer && !pcl_wb_pend_r;
    push      = t4 && ((is_jmp && ir_raw[12]) || ack);
    pop       = t4 && is_ret;
    push_val  = pc_r - risc_core_pkg::PC_STEP;  // pc runs one past the prefetched word
    alu_now   = risc_core_pkg::alu(ir_r.op, acc_r, opnd_r, st_r);
  end

  // ----------------------------------------------------------------
  // phase sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_r                    <= risc_core_pkg::PH_T1;
      instruction_phase_clocks_o <= 4'h1;
    end else begin
      case (phase_r)
        risc_core_pkg::PH_T1: begin
          phase_r                    <= risc_core_pkg::PH_T2;
          instruction_phase_clocks_o <= 4'h2;
        end
        risc_core_pkg::PH_T2: begin
          phase_r                    <= risc_core_pkg::PH_T3;
          instruction_phase_clocks_o <= 4'h4;
        end
        risc_core_pkg::PH_T3: begin
          phase_r                    <= risc_core_pkg::PH_T4;
          instruction_phase_clocks_o <= 4'h8;
        end
        default: begin
          phase_r                    <= risc_core_pkg::PH_T1;
          instruction_phase_clocks_o <= 4'h1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // program counter and prefetch
  // ----------------------------------------------------------------
  // the prefetch slot is marked empty on any transfer so the next cycle is a dummy
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_r       <= risc_core_pkg::RESET_VECTOR;
      pm_addr_o  <= risc_core_pkg::RESET_VECTOR;
      pf_r       <= '0;
      pf_valid_r <= 1'b0;
      ir_r       <= '0;
      ir_valid_r <= 1'b0;
    end else begin
      case (phase_r)
        risc_core_pkg::PH_T1: begin
          pm_addr_o  <= pc_r;
          pc_r       <= pc_r + risc_core_pkg::PC_STEP;
          ir_r       <= pf_r;
          ir_valid_r <= pf_valid_r;
        end
        risc_core_pkg::PH_T4: begin
          pf_r       <= risc_core_pkg::instr_s'(pm_data_i);
          pf_valid_r <= !(xfer || pcl_wb_pend_r || ack);
          if (is_jmp) begin
            pc_r <= ir_raw[11:0];
          end else if (is_ret) begin
            pc_r <= stk_r[0];
          end else if (pcl_wr) begin
            pc_r <= {pc_r[11:8], res_r.val};
          end else if (pcl_wb_go) begin
            pc_r <= {pc_r[11:8], pcl_wb_val_r};
          end else if (ack) begin
            pc_r <= INT_VECTOR;
          end
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // operand fetch, alu and data memory
  // ----------------------------------------------------------------
  // the low byte answers from the live counter instead of data memory
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      opnd_r   <= 8'h00;
      res_r    <= '0;
      dm_req_o <= '0;
    end else begin
      case (phase_r)
        risc_core_pkg::PH_T1: dm_req_o.addr <= pf_r.addr;
        risc_core_pkg::PH_T2: begin
          opnd_r <= (dm_req_o.addr == risc_core_pkg::PCL_DM_ADDR) ?
                    pc_r[7:0] : dm_rdata_i;
        end
        risc_core_pkg::PH_T3: begin
          res_r          <= alu_now;
          dm_req_o.wdata <= alu_now.val;
          dm_req_o.we    <= wr_mem && (ir_r.addr != risc_core_pkg::PCL_DM_ADDR);
        end
        default: dm_req_o.we <= 1'b0;
      endcase
    end
  end

  // accumulator and status commit at the end of the cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_r <= 8'h00;
      st_r  <= '0;
    end else if (t4 && alu_op) begin
      if (wr_acc) begin
        acc_r <= res_r.val;
      end
      st_r <= risc_core_pkg::status_s'((st_r & ~res_r.upd) | (res_r.st & res_r.upd));
    end
  end

  // ----------------------------------------------------------------
  // return stack
  // ----------------------------------------------------------------
  // shift structure: a push on a full stack drops the deepest entry
  always_ff @(posedge clk_i) begin
    if (push) begin
      for (int i = STACK_DEPTH - 1; i > 0; i--) begin
        stk_r[i] <= stk_r[i-1];
      end
      stk_r[0] <= push_val;
    end else if (pop) begin
      for (int i = 0; i < STACK_DEPTH - 1; i++) begin
        stk_r[i] <= stk_r[i+1];
      end
    end
  end

  // pointer counts used levels and saturates at full
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sp_r <= '0;
    end else if (push && !full) begin
      sp_r <= sp_r + 1'b1;
    end else if (pop && sp_r != '0) begin
      sp_r <= sp_r - 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // interrupt request and acknowledge
  // ----------------------------------------------------------------
  // a new request in the acknowledge cycle wins over the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_pend_r <= 1'b0;
      int_ack_o  <= 1'b0;
    end else begin
      int_pend_r <= irq_i || (int_pend_r && !(t4 && ack));
      int_ack_o  <= t4 && ack;
    end
  end

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  assign wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

  // one wait state; unmapped reads give zero and unmapped writes are dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      case (wb_adr_i)
        risc_core_pkg::REG_PCL:  wb_dat_o <= {24'h00_0000, pc_r[7:0]};
        risc_core_pkg::REG_STAT: wb_dat_o <= risc_core_pkg::stat_rd_s'{
          zero: '0, pend: int_pend_r, full: full,
          sp: risc_core_pkg::STAT_SP_W'(sp_r), flags: st_r};
        risc_core_pkg::REG_ACC:  wb_dat_o <= {24'h00_0000, acc_r};
        risc_core_pkg::REG_CTRL: wb_dat_o <= {31'h0000_0000, int_en_r};
        default:                 wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // software writes; a pending low byte jump is consumed in the last phase
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_en_r      <= 1'b0;
      pcl_wb_pend_r <= 1'b0;
      pcl_wb_val_r  <= 8'h00;
    end else begin
      if (wb_wr && wb_adr_i == risc_core_pkg::REG_CTRL
          && wb_sel_i[risc_core_pkg::PCL_LANE]) begin
        int_en_r <= wb_dat_i[risc_core_pkg::CTRL_INT_EN_BIT];
      end
      if (wb_wr && wb_adr_i == risc_core_pkg::REG_PCL
          && wb_sel_i[risc_core_pkg::PCL_LANE]) begin
        pcl_wb_pend_r <= 1'b1;
        pcl_wb_val_r  <= wb_dat_i[7:0];
      end else if (t4 && pcl_wb_go) begin
        pcl_wb_pend_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_PHASE_ORDER: assert property ((phase_r == risc_core_pkg::PH_T1) |=>
    (phase_r == risc_core_pkg::PH_T2) ##1 (phase_r == risc_core_pkg::PH_T3)
    ##1 (phase_r == risc_core_pkg::PH_T4)) else $error("phase order broken");
  AST_CYCLE_LEN: assert property ((phase_r == risc_core_pkg::PH_T1) |->
    ##4 (phase_r == risc_core_pkg::PH_T1)) else $error("cycle not four phases");
  AST_FETCH_STEP: assert property ((phase_r == risc_core_pkg::PH_T2) |->
    (pc_r == pm_addr_o + risc_core_pkg::PC_STEP)) else $error("pc not one past fetch");
  AST_JUMP_DUMMY: assert property ((t4 && is_jmp) |->
    ##2 (!ir_valid_r && pm_addr_o == $past(ir_raw[11:0], 2))) else $error("jump no dummy");
  AST_PCL_PAGE: assert property ((t4 && pcl_wr) |=>
    (pc_r[11:8] == $past(pc_r[11:8]) && !pf_valid_r)) else $error("low byte jump left page");
  AST_SKIP_DUMMY: assert property ((t4 && skip) |=>
    !pf_valid_r) else $error("skip kept prefetch");
  AST_SP_RANGE: assert property (sp_r <= SP_FULL) else $error("stack pointer past depth");
  AST_PUSH: assert property (push |=>
    (stk_r[0] == $past(push_val))) else $error("push lost value");
  AST_POP: assert property ((pop && sp_r != '0) |=>
    (sp_r == $past(sp_r) - 1'b1 && pc_r == $past(stk_r[0]))) else $error("pop wrong");
  AST_RESET_SP: assert property ($fell(rst_i) |-> (sp_r == '0)) else $error("sp not reset");
  AST_FULL_HOLD: assert property ((t4 && full && int_pend_r) |=>
    (int_pend_r && !int_ack_o)) else $error("ack given on full stack");
  AST_ZERO_FLAG: assert property ((t4 && alu_op && res_r.upd.z) |=>
    (st_r.z == ($past(res_r.val) == 8'h00))) else $error("zero flag wrong");

endmodule // risc_core_sequencer

// ### logic/risc_core_pkg.sv
// shared constants, types and alu for the risc core sequencer
package risc_core_pkg;

  // ----------------------------------------------------------------
  // sizes, vectors and addresses
  // ----------------------------------------------------------------
  localparam int          STACK_DEPTH_DEF = 6;
  localparam int          STAT_SP_W       = 3;
  localparam logic [11:0] RESET_VECTOR    = 12'h000;
  localparam logic [11:0] INT_VECTOR_DEF  = 12'h004;
  localparam logic [11:0] PC_STEP         = 12'h001;
  localparam logic [7:0]  PCL_DM_ADDR     = 8'h06;
  localparam logic [1:0]  CLS_JUMP        = 2'h3;
  localparam int          CTRL_INT_EN_BIT = 0;
  localparam int          PCL_LANE        = 0;

  // wishbone register byte addresses
  localparam logic [3:0] REG_PCL  = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_ACC  = 4'h8;
  localparam logic [3:0] REG_CTRL = 4'hC;

  // decimal adjust figures
  localparam logic [7:0] DAA_LO  = 8'h06;
  localparam logic [7:0] DAA_HI  = 8'h60;
  localparam logic [3:0] BCD_MAX = 4'h9;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_T1 = 2'b00, PH_T2 = 2'b01, PH_T3 = 2'b10, PH_T4 = 2'b11
  } phase_e;

  typedef enum logic [4:0] {
    OP_NOP = 5'b00000, OP_ADD = 5'b00001, OP_ADC  = 5'b00010, OP_SUB = 5'b00011,
    OP_SBC = 5'b00100, OP_DAA = 5'b00101, OP_AND  = 5'b00110, OP_OR  = 5'b00111,
    OP_XOR = 5'b01000, OP_CPL = 5'b01001, OP_RR   = 5'b01010, OP_RRC = 5'b01011,
    OP_RL  = 5'b01100, OP_RLC = 5'b01101, OP_INC  = 5'b01110, OP_DEC = 5'b01111,
    OP_SZ  = 5'b10000, OP_SNZ = 5'b10001, OP_SIZ  = 5'b10010, OP_SDZ = 5'b10011,
    OP_RET = 5'b10100, OP_RETURN_FROM_INTERRUPT = 5'b10101
  } op_e;

  typedef struct packed {
    logic [1:0] cls;
    op_e        op;
    logic       to_mem;
    logic [7:0] addr;
  } instr_s;

  typedef struct packed {
    logic ov;
    logic z;
    logic ac;
    logic c;
  } status_s;

  typedef struct packed {
    logic [7:0] val;
    status_s    st;
    status_s    upd;
  } alu_res_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       we;
  } dm_req_s;

  typedef struct packed {
    logic [22:0]          zero;
    logic                 pend;
    logic                 full;
    logic [STAT_SP_W-1:0] sp;
    status_s              flags;
  } stat_rd_s;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // ops that store a result somewhere
  function automatic logic writes(input op_e op);
    return !(op inside {OP_NOP, OP_SZ, OP_SNZ, OP_RET, OP_RETURN_FROM_INTERRUPT});
  endfunction

  // subtract is add of the inverted operand, carry set means no borrow
  function automatic alu_res_s alu(input op_e op, input logic [7:0] a,
                                   input logic [7:0] m, input status_s st);
    alu_res_s   r;
    logic [7:0] b;
    logic       cin;
    logic [8:0] s;
    logic [4:0] h;
    r   = '0;
    b   = (op == OP_SUB || op == OP_SBC) ? ~m : m;
    cin = (op == OP_ADC || op == OP_SBC) ? st.c : (op == OP_SUB);
    s   = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    h   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    case (op)
      OP_ADD, OP_ADC, OP_SUB, OP_SBC: begin
        r.val   = s[7:0];
        r.st.c  = s[8];
        r.st.ac = h[4];
        r.st.ov = (a[7] == b[7]) && (s[7] != a[7]);
        r.upd   = '1;
      end
      OP_DAA: begin
        s = {1'b0, a};
        if (a[3:0] > BCD_MAX || st.ac) begin
          s = s + {1'b0, DAA_LO};
        end
        if (s[7:4] > BCD_MAX || st.c || s[8]) begin
          s = s + {1'b0, DAA_HI};
        end
        r.val   = s[7:0];
        r.st.c  = s[8] | st.c;
        r.upd.c = 1'b1;
      end
      OP_AND:         r.val = a & m;
      OP_OR:          r.val = a | m;
      OP_XOR:         r.val = a ^ m;
      OP_CPL:         r.val = ~m;
      OP_RR:          r.val = {m[0], m[7:1]};
      OP_RL:          r.val = {m[6:0], m[7]};
      OP_RRC: begin
        r.val   = {st.c, m[7:1]};
        r.st.c  = m[0];
        r.upd.c = 1'b1;
      end
      OP_RLC: begin
        r.val   = {m[6:0], st.c};
        r.st.c  = m[7];
        r.upd.c = 1'b1;
      end
      OP_INC, OP_SIZ: r.val = m + 8'h01;
      OP_DEC, OP_SDZ: r.val = m - 8'h01;
      OP_SZ, OP_SNZ:  r.val = m;
      default:        r.val = a;
    endcase
    r.st.z  = (r.val == 8'h00);
    r.upd.z = (op inside {OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_OR,
                          OP_XOR, OP_CPL, OP_INC, OP_DEC});
    return r;
  endfunction

endpackage

// ### testbench/memory_partner.sv
// program memory and data register file model facing the sequencer
`timescale 1ns/1ps
module memory_partner (
  // clock
  input  wire logic                   clk_i,
  // program memory side
  input  wire logic [11:0]            pm_addr_i,
  output logic      [15:0]            pm_data_o,
  // data memory side
  input  wire risc_core_pkg::dm_req_s dm_req_i,
  output logic      [7:0]             dm_rdata_o
);
  logic [15:0] rom [0:4095];
  logic [7:0]  ram [0:255];
  // reads follow the address at once, the sequencer picks its own sampling edge
  assign pm_data_o  = rom[pm_addr_i];
  assign dm_rdata_o = ram[dm_req_i.addr];
  // write lands on the edge that closes the write phase
  // plain always: the bench preloads this array before the clock starts
  always @(posedge clk_i) begin
    if (dm_req_i.we) begin
      ram[dm_req_i.addr] <= dm_req_i.wdata;
    end
  end
endmodule // memory_partner

// ### testbench/tb_risc_core_sequencer.sv
// self-checking bench for the risc core sequencer
`timescale 1ns/1ps
module tb_risc_core_sequencer;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic                   clk_i      = 1'b0;
  logic                   rst_i      = 1'b1;
  logic                   wb_cyc_i   = 1'b0;
  logic                   wb_stb_i   = 1'b0;
  logic                   wb_we_i    = 1'b0;
  logic [3:0]             wb_adr_i   = 4'h0;
  logic [3:0]             wb_sel_i   = 4'hF;
  logic [31:0]            wb_dat_i   = 32'h0000_0000;
  logic                   irq_i      = 1'b0;
  logic [31:0]            wb_dat_o;
  logic                   wb_ack_o;
  logic [11:0]            pm_addr_o;
  logic [15:0]            pm_data_i;
  risc_core_pkg::dm_req_s dm_req_o;
  logic [7:0]             dm_rdata_i;
  logic                   int_ack_o;
  logic [3:0]             phase;
  int                     acks       = 0;
  logic [31:0]            rd;
  int                     checks     = 0;
  int                     fail_count = 0;

  // 25 MHz system clock
  always #20 clk_i = ~clk_i;

  risc_core_sequencer risc_core_sequencer_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pm_addr_o(pm_addr_o),
    .pm_data_i(pm_data_i), .dm_req_o(dm_req_o), .dm_rdata_i(dm_rdata_i),
    .irq_i(irq_i), .int_ack_o(int_ack_o), .instruction_phase_clocks_o(phase));

  memory_partner memory_partner_i (
    .clk_i(clk_i), .pm_addr_i(pm_addr_o), .pm_data_o(pm_data_i),
    .dm_req_i(dm_req_o), .dm_rdata_o(dm_rdata_i));

  // count acknowledge pulses, each stands one cycle only
  always @(posedge clk_i) begin
    if (int_ack_o === 1'b1) acks <= acks + 1;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // classic single cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    cmp(n < 50, 1);
  endtask

  // bounded wait for a fetch address; pm_addr_o stands four clocks
  task automatic wait_pc(input logic [11:0] a);
    int n;
    n = 0;
    while (pm_addr_o !== a && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    cmp({20'h0_0000, pm_addr_o}, {20'h0_0000, a});
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    wb(1'b0, risc_core_pkg::REG_STAT, 32'h0000_0000);
    cmp({29'h0, rd[6:4]}, 0);
    for (int i = 0; i < 8 && phase !== 4'h1; i++) @(posedge clk_i);
    for (int i = 0; i < 4; i++) begin
      cmp({28'h000_0000, phase}, {28'h000_0000, 4'h1 << i});
      @(posedge clk_i);
    end
  endtask

  // add to acc, add to memory, call and return, then idle loop
  task automatic t_program();
    wait_pc(12'h020);
    wait_pc(12'h003);
    wait_pc(12'h008);
    wb(1'b0, risc_core_pkg::REG_ACC, 32'h0000_0000);
    cmp(rd & 32'h0000_00FF, 32'h0000_0005);
    cmp({24'h00_0000, memory_partner_i.ram[8'h11]}, 32'h0000_0008);
    wb(1'b1, risc_core_pkg::REG_ACC, 32'h0000_00FF);
    wb(1'b0, risc_core_pkg::REG_ACC, 32'h0000_0000);
    cmp(rd & 32'h0000_00FF, 32'h0000_0005);
    wb(1'b0, 4'h2, 32'h0000_0000);
    cmp(rd, 32'h0000_0000);
  endtask

  task automatic t_irq();
    wb(1'b1, risc_core_pkg::REG_CTRL, 32'h0000_0001);
    @(posedge clk_i);
    irq_i <= 1'b1;
    @(posedge clk_i);
    irq_i <= 1'b0;
    wait_pc(12'h004);
    cmp(acks, 1);
    wait_pc(12'h008);
    wb(1'b0, risc_core_pkg::REG_STAT, 32'h0000_0000);
    cmp({29'h0, rd[6:4]}, 0);
  endtask

  // low byte write jumps inside the page, the read gives the live counter low bits, one past 0x040
  task automatic t_pcl();
    wb(1'b1, risc_core_pkg::REG_PCL, 32'h0000_0040);
    wait_pc(12'h040);
    // start so the read lands in the last phase of the dummy cycle fetching 0x040
    for (int i = 0; i < 16 && !(phase === 4'h2 && pm_addr_o === 12'h040); i++) begin
      @(posedge clk_i);
    end
    wb(1'b0, risc_core_pkg::REG_PCL, 32'h0000_0000);
    cmp(rd, 32'h0000_0041);
  endtask

  // sub, xor to memory, rotate through carry, taken increment skip over a complement
  task automatic t_alu();
    wb(1'b1, risc_core_pkg::REG_PCL, 32'h0000_0060);
    wait_pc(12'h065);
    wait_pc(12'h040);
    wb(1'b0, risc_core_pkg::REG_ACC, 32'h0000_0000);
    cmp(rd, 32'h0000_0003);
    cmp({24'h00_0000, memory_partner_i.ram[8'h20]}, 32'h0000_000B);
    cmp({24'h00_0000, memory_partner_i.ram[8'h22]}, 32'h0000_0000);
  endtask

  // endless self call fills the stack, then a return lets the held interrupt in
  task automatic t_stack();
    wb(1'b1, risc_core_pkg::REG_PCL, 32'h0000_0050);
    repeat (80) @(posedge clk_i);
    irq_i <= 1'b1;
    @(posedge clk_i);
    irq_i <= 1'b0;
    repeat (16) @(posedge clk_i);
    wb(1'b0, risc_core_pkg::REG_STAT, 32'h0000_0000);
    cmp({29'h0000_0000, rd[6:4]}, 32'h0000_0006);
    cmp({30'h0000_0000, rd[8:7]}, 32'h0000_0003);
    cmp(acks, 1);
    wb(1'b1, risc_core_pkg::REG_PCL, 32'h0000_0020);
    wait_pc(risc_core_pkg::INT_VECTOR_DEF);
    wait_pc(12'h040);
    cmp(acks, 2);
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    for (int i = 0; i < 4096; i++) memory_partner_i.rom[i] = 16'h0000;
    for (int i = 0; i < 256; i++) memory_partner_i.ram[i] = 8'h00;
    memory_partner_i.ram[8'h10] = 8'h05;
    memory_partner_i.ram[8'h11] = 8'h03;
    memory_partner_i.rom[0] = 16'h0210;
    memory_partner_i.rom[1] = 16'h0311;
    memory_partner_i.rom[2] = 16'hD020;
    memory_partner_i.rom[3] = 16'hC008;
    memory_partner_i.rom[4] = 16'h2A00;
    memory_partner_i.rom[9] = 16'hC008;
    memory_partner_i.rom[12'h020] = 16'h2800;
    memory_partner_i.rom[12'h040] = 16'hC040;
    memory_partner_i.ram[8'h20] = 8'h0F;
    memory_partner_i.ram[8'h21] = 8'h01;
    memory_partner_i.ram[8'h22] = 8'hFF;
    memory_partner_i.rom[12'h050] = 16'hD050;
    memory_partner_i.rom[12'h051] = 16'hC040;
    memory_partner_i.rom[12'h060] = 16'h0621;
    memory_partner_i.rom[12'h061] = 16'h1120;
    memory_partner_i.rom[12'h062] = 16'h1A21;
    memory_partner_i.rom[12'h063] = 16'h2522;
    memory_partner_i.rom[12'h064] = 16'h1222;
    memory_partner_i.rom[12'h065] = 16'hC040;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_program();
    t_irq();
    t_pcl();
    t_alu();
    t_stack();
    results();
  end

  // the whole run needs well under a thousand clocks
  initial begin
    repeat (5000) @(posedge clk_i);
    fail_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    results();
  end
endmodule // tb_risc_core_sequencer
